/* File: hdl/cipher_bridge_pkg.sv */
/*
  constants, register offsets and carrier types for the cipher test register bridge.
  assumes a 32-bit host bus with word addresses and a separate core-side clock.
*/
package cipher_bridge_pkg;

  // host word address layout
  localparam int HOST_ADDR_W = 14;
  localparam int MEM_ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int SEL_LSB = 9;
  localparam int SEL_MSB = 13;
  localparam logic [4:0] SEL_PLAIN_MEM = 5'h01;
  localparam logic [4:0] SEL_CIPHER_MEM = 5'h02;

  // register byte offsets
  localparam logic [15:0] OFF_PLAIN_PTR = 16'h0000;
  localparam logic [15:0] OFF_CIPHER_PTR = 16'h0004;
  localparam logic [15:0] OFF_ENC_COUNT = 16'h0008;
  localparam logic [15:0] OFF_DEC_COUNT = 16'h000C;
  localparam logic [15:0] OFF_ENC_VERSION = 16'h0018;
  localparam logic [15:0] OFF_DEC_VERSION = 16'h001C;
  localparam logic [15:0] OFF_ENC_KEY0 = 16'h0020;
  localparam logic [15:0] OFF_DEC_KEY0 = 16'h0040;

  // field positions
  localparam int PTR_W = 7;
  localparam int COUNT_W = 7;
  localparam int KEY_BUSY_BIT = 8;
  localparam int INPUT_BUSY_BIT = 7;

  // reset values
  localparam logic [6:0] PTR_RESET = 7'h00;
  localparam logic [6:0] COUNT_RESET = 7'h00;
  localparam logic [127:0] KEY_RESET = 128'h0;

  // cycle counts
  localparam logic [3:0] KEY_SET_CYCLES = 4'hA;

  // request handed from the host side to the core side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [13:0] addr;
    logic [31:0] data;
    logic [3:0] lanes;
  } cfg_req_t;

  // status reported by one cipher core
  typedef struct packed {
    logic input_busy;
    logic block_done;
    logic [31:0] version;
  } core_status_t;

endpackage

/* File: hdl/host_bus_bridge.sv */
/*
  host bus bridge: sample memories on the host clock, a toggle-handshake converter into
  the core clock, and the core register bank that controls the encryptor and decryptor.
  assumes the host holds a request until host_ready_o and that the cipher cores sit outside.
*/
// Summary of operation
// - decode address [13:9] for sample memories
// - other accesses go to the converter
// - host and core logic on separate clocks
// - core side sees 32-bit word-addressed registers
// - write strobe with address, data, lanes
// - byte lane n qualifies data byte n
// - read request waits for read acknowledge
// - read data captured with acknowledge cycle
// - memories hold plaintext and ciphertext samples
// - offset 0x0 holds plain memory pointer
// - offset 0x4 holds cipher memory pointer
// - encrypt status: key busy, input busy, count
// - writing encrypt count starts encryption
// - decrypt status: key busy, input busy, count
// - writing decrypt count starts decryption
// - version words at 0x18 and 0x1C
// - key word 0 write starts key setting
// - upper encryption key words load silently
// - decryption key at 0x40, word 0 starts
// - key setting busy for ten cycles
// - read acknowledge two cycles after request
`timescale 1ns/1ns
module host_bus_bridge (
  // clocks and reset
  input wire logic core_clk_i,
  input wire logic host_side_clk_i,
  input wire logic nrst_i,
  // host bus, host clock
  input wire logic [13:0] host_word_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [31:0] host_wr_data_i,
  input wire logic [3:0] host_byte_en_i,
  output logic host_ready_o,
  output logic host_rd_valid_o,
  output logic [31:0] host_rd_data_o,
  // encryptor side, core clock
  input wire cipher_bridge_pkg::core_status_t enc_status_i,
  output logic [127:0] enc_key_value_o,
  output logic enc_key_load_strobe_o,
  output logic enc_start_o,
  output logic [127:0] plain_row_o,
  // decryptor side, core clock
  input wire cipher_bridge_pkg::core_status_t dec_status_i,
  output logic [127:0] dec_key_value_o,
  output logic dec_key_load_strobe_o,
  output logic dec_input_valid_o,
  output logic [127:0] cipher_row_o
);

  typedef enum logic {H_IDLE, H_WAIT} host_state_t;

  // host side state
  host_state_t hstate_q, hstate_d;
  cipher_bridge_pkg::cfg_req_t hreq_q, hreq_d;
  logic req_tog_q, req_tog_d;
  logic hvalid_q, hvalid_d;
  logic [31:0] hdata_q, hdata_d;
  logic done_tog_q, done_tog_d;
  logic [31:0] cfg_rd_word_q, cfg_rd_word_d;
  logic done_s1_q, done_s2_q, done_s3_q;
  logic [31:0] plain_sample_mem [cipher_bridge_pkg::MEM_DEPTH];
  logic [31:0] cipher_sample_mem [cipher_bridge_pkg::MEM_DEPTH];
  logic [4:0] sel;
  logic [8:0] maddr;
  logic take, sel_plain, sel_cipher, done_evt;

  assign sel = host_word_addr_i[cipher_bridge_pkg::SEL_MSB:cipher_bridge_pkg::SEL_LSB];
  assign maddr = host_word_addr_i[cipher_bridge_pkg::MEM_ADDR_W-1:0];
  assign sel_plain = (sel == cipher_bridge_pkg::SEL_PLAIN_MEM);
  assign sel_cipher = (sel == cipher_bridge_pkg::SEL_CIPHER_MEM);
  assign take = (hstate_q == H_IDLE) && (host_wr_i || host_rd_i);
  assign done_evt = done_s2_q ^ done_s3_q;
  assign host_ready_o = (hstate_q == H_IDLE);
  assign host_rd_valid_o = hvalid_q;
  assign host_rd_data_o = hdata_q;

  always_comb begin
    hstate_d = hstate_q;
    hreq_d = hreq_q;
    req_tog_d = req_tog_q;
    hvalid_d = 1'b0;
    hdata_d = hdata_q;
    unique case (hstate_q)
      H_IDLE: begin
        if (take && (sel_plain || sel_cipher)) begin
          hvalid_d = host_rd_i;
          hdata_d = sel_plain ? plain_sample_mem[maddr] : cipher_sample_mem[maddr];
        end else if (take) begin
          // everything outside the sample memories crosses to the core side
          hreq_d = '{wr: host_wr_i, rd: host_rd_i, addr: host_word_addr_i,
                     data: host_wr_data_i, lanes: host_byte_en_i};
          req_tog_d = ~req_tog_q;
          hstate_d = H_WAIT;
        end
      end
      H_WAIT: begin
        if (done_evt) begin
          hvalid_d = hreq_q.rd;
          hdata_d = cfg_rd_word_q;
          hstate_d = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge host_side_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hstate_q <= H_IDLE;
      hreq_q <= '0;
      req_tog_q <= 1'b0;
      hvalid_q <= 1'b0;
      hdata_q <= 32'h0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      hstate_q <= hstate_d;
      hreq_q <= hreq_d;
      req_tog_q <= req_tog_d;
      hvalid_q <= hvalid_d;
      hdata_q <= hdata_d;
      done_s1_q <= done_tog_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  // sample memory host port, one byte lane per enable bit
  always_ff @(posedge host_side_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (take && host_wr_i && host_byte_en_i[i] && sel_plain) begin
        plain_sample_mem[maddr][8*i +: 8] <= host_wr_data_i[8*i +: 8];
      end
      if (take && host_wr_i && host_byte_en_i[i] && sel_cipher) begin
        cipher_sample_mem[maddr][8*i +: 8] <= host_wr_data_i[8*i +: 8];
      end
    end
  end

  // core side converter and register bank
  logic req_s1_q, req_s2_q, req_s3_q;
  logic new_req;
  logic cfg_wr_strobe, cfg_rd_request;
  logic [13:0] cfg_word_addr;
  logic [31:0] cfg_wr_word;
  logic [3:0] cfg_byte_lanes;
  logic cfg_rd_pend_q;
  logic cfg_rd_ack_q;
  logic [6:0] plain_mem_ptr_q, plain_mem_ptr_d;
  logic [6:0] cipher_mem_ptr_q, cipher_mem_ptr_d;
  logic [6:0] enc_block_count_q, enc_block_count_d;
  logic [6:0] dec_block_count_q, dec_block_count_d;
  logic [127:0] enc_key_value_q, enc_key_value_d;
  logic [127:0] dec_key_value_q, dec_key_value_d;
  logic enc_strobe_q, enc_strobe_d, dec_strobe_q, dec_strobe_d;
  logic enc_start_q, enc_start_d, dec_valid_q, dec_valid_d;
  logic [3:0] enc_kcnt_q, enc_kcnt_d, dec_kcnt_q, dec_kcnt_d;
  logic enc_key_load_busy, dec_key_load_busy;
  logic [127:0] plain_row_q, cipher_row_q;
  logic [8:0] row_base_p, row_base_c;

  assign new_req = req_s2_q ^ req_s3_q;
  assign cfg_word_addr = hreq_q.addr;
  assign cfg_wr_word = hreq_q.data;
  assign cfg_byte_lanes = hreq_q.lanes;
  assign cfg_wr_strobe = new_req && hreq_q.wr;
  assign cfg_rd_request = new_req && hreq_q.rd;
  assign enc_key_load_busy = (enc_kcnt_q != 4'h0);
  assign dec_key_load_busy = (dec_kcnt_q != 4'h0);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [13:0] a, input logic [15:0] off);
    return a == 14'(off >> 2);
  endfunction

  always_comb begin
    logic [31:0] w;
    w = 32'h0;
    plain_mem_ptr_d = plain_mem_ptr_q;
    cipher_mem_ptr_d = cipher_mem_ptr_q;
    enc_key_value_d = enc_key_value_q;
    dec_key_value_d = dec_key_value_q;
    enc_strobe_d = 1'b0;
    dec_strobe_d = 1'b0;
    enc_start_d = 1'b0;
    dec_valid_d = 1'b0;
    enc_kcnt_d = enc_key_load_busy ? enc_kcnt_q - 4'h1 : enc_kcnt_q;
    dec_kcnt_d = dec_key_load_busy ? dec_kcnt_q - 4'h1 : dec_kcnt_q;
    enc_block_count_d = enc_block_count_q;
    dec_block_count_d = dec_block_count_q;
    if (enc_status_i.block_done && enc_block_count_q != 7'h00) begin
      enc_block_count_d = enc_block_count_q - 7'h01;
    end
    if (dec_status_i.block_done && dec_block_count_q != 7'h00) begin
      dec_block_count_d = dec_block_count_q - 7'h01;
    end
    if (cfg_wr_strobe) begin
      w = merge(32'h0, cfg_wr_word, cfg_byte_lanes);
      if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_PLAIN_PTR) && cfg_byte_lanes[0]) begin
        plain_mem_ptr_d = w[6:0];
      end
      if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_CIPHER_PTR) && cfg_byte_lanes[0]) begin
        cipher_mem_ptr_d = w[6:0];
      end
      if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_ENC_COUNT) && cfg_byte_lanes[0]) begin
        enc_block_count_d = w[6:0];
        enc_start_d = 1'b1;
      end
      if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_DEC_COUNT) && cfg_byte_lanes[0]) begin
        dec_block_count_d = w[6:0];
        dec_valid_d = 1'b1;
      end
      for (int k = 0; k < 4; k++) begin
        if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_ENC_KEY0 + 16'(4*k))) begin
          enc_key_value_d[32*k +: 32] = merge(enc_key_value_q[32*k +: 32], cfg_wr_word, cfg_byte_lanes);
          if (k == 0) begin
            enc_strobe_d = 1'b1;
            enc_kcnt_d = cipher_bridge_pkg::KEY_SET_CYCLES;
          end
        end
        if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_DEC_KEY0 + 16'(4*k))) begin
          dec_key_value_d[32*k +: 32] = merge(dec_key_value_q[32*k +: 32], cfg_wr_word, cfg_byte_lanes);
          if (k == 0) begin
            dec_strobe_d = 1'b1;
            dec_kcnt_d = cipher_bridge_pkg::KEY_SET_CYCLES;
          end
        end
      end
    end
  end

  // read mux, evaluated in the cycle after the request
  always_comb begin
    cfg_rd_word_d = cfg_rd_word_q;
    if (cfg_rd_pend_q) begin
      cfg_rd_word_d = 32'h0;
      if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_PLAIN_PTR)) begin
        cfg_rd_word_d = {25'h0, plain_mem_ptr_q};
      end else if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_CIPHER_PTR)) begin
        cfg_rd_word_d = {25'h0, cipher_mem_ptr_q};
      end else if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_ENC_COUNT)) begin
        cfg_rd_word_d = {23'h0, enc_key_load_busy, enc_status_i.input_busy, enc_block_count_q};
      end else if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_DEC_COUNT)) begin
        cfg_rd_word_d = {23'h0, dec_key_load_busy, dec_status_i.input_busy, dec_block_count_q};
      end else if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_ENC_VERSION)) begin
        cfg_rd_word_d = enc_status_i.version;
      end else if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_DEC_VERSION)) begin
        cfg_rd_word_d = dec_status_i.version;
      end else begin
        for (int k = 0; k < 4; k++) begin
          if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_ENC_KEY0 + 16'(4*k))) begin
            cfg_rd_word_d = enc_key_value_q[32*k +: 32];
          end
          if (hit(cfg_word_addr, cipher_bridge_pkg::OFF_DEC_KEY0 + 16'(4*k))) begin
            cfg_rd_word_d = dec_key_value_q[32*k +: 32];
          end
        end
      end
    end
  end

  // writes finish at once; reads finish with the acknowledge
  assign done_tog_d = (cfg_wr_strobe || cfg_rd_ack_q) ? ~done_tog_q : done_tog_q;
  assign row_base_p = {plain_mem_ptr_q, 2'b00};
  assign row_base_c = {cipher_mem_ptr_q, 2'b00};

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      done_tog_q <= 1'b0;
      cfg_rd_pend_q <= 1'b0;
      cfg_rd_ack_q <= 1'b0;
      cfg_rd_word_q <= 32'h0;
      plain_mem_ptr_q <= cipher_bridge_pkg::PTR_RESET;
      cipher_mem_ptr_q <= cipher_bridge_pkg::PTR_RESET;
      enc_block_count_q <= cipher_bridge_pkg::COUNT_RESET;
      dec_block_count_q <= cipher_bridge_pkg::COUNT_RESET;
      enc_key_value_q <= cipher_bridge_pkg::KEY_RESET;
      dec_key_value_q <= cipher_bridge_pkg::KEY_RESET;
      enc_strobe_q <= 1'b0;
      dec_strobe_q <= 1'b0;
      enc_start_q <= 1'b0;
      dec_valid_q <= 1'b0;
      enc_kcnt_q <= 4'h0;
      dec_kcnt_q <= 4'h0;
    end else begin
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      done_tog_q <= done_tog_d;
      cfg_rd_pend_q <= cfg_rd_request;
      cfg_rd_ack_q <= cfg_rd_pend_q;
      cfg_rd_word_q <= cfg_rd_word_d;
      plain_mem_ptr_q <= plain_mem_ptr_d;
      cipher_mem_ptr_q <= cipher_mem_ptr_d;
      enc_block_count_q <= enc_block_count_d;
      dec_block_count_q <= dec_block_count_d;
      enc_key_value_q <= enc_key_value_d;
      dec_key_value_q <= dec_key_value_d;
      enc_strobe_q <= enc_strobe_d;
      dec_strobe_q <= dec_strobe_d;
      enc_start_q <= enc_start_d;
      dec_valid_q <= dec_valid_d;
      enc_kcnt_q <= enc_kcnt_d;
      dec_kcnt_q <= dec_kcnt_d;
    end
  end

  // sample memory core port: one 128-bit row at the pointer
  always_ff @(posedge core_clk_i) begin
    plain_row_q <= {plain_sample_mem[row_base_p + 9'h3], plain_sample_mem[row_base_p + 9'h2],
                    plain_sample_mem[row_base_p + 9'h1], plain_sample_mem[row_base_p]};
    cipher_row_q <= {cipher_sample_mem[row_base_c + 9'h3], cipher_sample_mem[row_base_c + 9'h2],
                     cipher_sample_mem[row_base_c + 9'h1], cipher_sample_mem[row_base_c]};
  end

  assign enc_key_value_o = enc_key_value_q;
  assign dec_key_value_o = dec_key_value_q;
  assign enc_key_load_strobe_o = enc_strobe_q;
  assign dec_key_load_strobe_o = dec_strobe_q;
  assign enc_start_o = enc_start_q;
  assign dec_input_valid_o = dec_valid_q;
  assign plain_row_o = plain_row_q;
  assign cipher_row_o = cipher_row_q;

endmodule // host_bus_bridge

/* File: verif/cipher_bridge_assertions.sv */
/*
  port timing checker for the host bus bridge.
  assumes both clocks run freely and nrst_i resets both domains.
*/
`timescale 1ns/1ns
module cipher_bridge_checker (
  // clocks and reset
  input wire logic core_clk_i,
  input wire logic host_side_clk_i,
  input wire logic nrst_i,
  // host bus
  input wire logic [13:0] host_word_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic host_ready_o,
  input wire logic host_rd_valid_o,
  // core side strobes
  input wire logic enc_key_load_strobe_o,
  input wire logic dec_key_load_strobe_o,
  input wire logic enc_start_o,
  input wire logic dec_input_valid_o
);
  logic mem_sel;
  logic take;
  assign mem_sel = host_word_addr_i[13:9] inside {5'h01, 5'h02};
  assign take = host_ready_o && (host_wr_i || host_rd_i);
  a_mem_read_latency: assert property (
    @(posedge host_side_clk_i) disable iff (!nrst_i) take && host_rd_i && mem_sel |=> host_rd_valid_o)
    else $error("memory read not answered next cycle");
  a_reg_take_stall: assert property (
    @(posedge host_side_clk_i) disable iff (!nrst_i) take && !mem_sel |=> !host_ready_o)
    else $error("register access did not stall the host");
  a_reg_read_answer: assert property (
    @(posedge host_side_clk_i) disable iff (!nrst_i) take && host_rd_i && !mem_sel |=> ##[1:60] host_rd_valid_o)
    else $error("register read never answered");
  a_reg_write_release: assert property (
    @(posedge host_side_clk_i) disable iff (!nrst_i)
    take && host_wr_i && !mem_sel |=> !host_ready_o ##[1:60] host_ready_o)
    else $error("register write never completed");
  a_enc_key_pulse: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i) $rose(enc_key_load_strobe_o) |=> !enc_key_load_strobe_o)
    else $error("encrypt key strobe longer than one cycle");
  a_dec_key_pulse: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i) dec_key_load_strobe_o |=> !dec_key_load_strobe_o)
    else $error("decrypt key strobe longer than one cycle");
  a_enc_start_pulse: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i) enc_start_o |=> !enc_start_o)
    else $error("encrypt start longer than one cycle");
  a_dec_valid_pulse: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i) dec_input_valid_o |=> !dec_input_valid_o)
    else $error("decrypt input valid longer than one cycle");
  a_one_write_effect: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    enc_key_load_strobe_o |-> !enc_start_o && !dec_input_valid_o && !dec_key_load_strobe_o)
    else $error("two write effects in one cycle");
  c_mem_read: cover property (@(posedge host_side_clk_i) take && host_rd_i && mem_sel);
  c_reg_read: cover property (@(posedge host_side_clk_i) take && host_rd_i && !mem_sel);
  c_key_set: cover property (@(posedge core_clk_i) enc_key_load_strobe_o);
endmodule // cipher_bridge_checker

bind host_bus_bridge cipher_bridge_checker chk_u (.core_clk_i, .host_side_clk_i, .nrst_i, .host_word_addr_i,
  .host_wr_i, .host_rd_i, .host_ready_o, .host_rd_valid_o, .enc_key_load_strobe_o, .dec_key_load_strobe_o,
  .enc_start_o, .dec_input_valid_o);

/* File: verif/host_cpu_model.sv */
/*
  host processor model: one request at a time on the bridge host bus.
  assumes the bench calls access one call after another.
*/
`timescale 1ns/1ns
module host_cpu_model (
  // clock
  input wire logic clk_i,
  // answers
  input wire logic ready_i,
  input wire logic rd_valid_i,
  input wire logic [31:0] rd_data_i,
  // requests
  output logic [13:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] byte_en_o
);
  // accesses whose answer never came
  int stalls;
  initial begin
    addr_o = 14'h3FFF;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wr_data_o = 32'h0;
    byte_en_o = 4'h0;
  end
  task automatic access(input logic [13:0] addr, input logic wr, input logic [31:0] data,
    input logic [3:0] lanes, output logic [31:0] rdata);
    int i;
    i = 0;
    rdata = 32'h0;
    @(posedge clk_i);
    addr_o <= addr;
    wr_o <= wr;
    rd_o <= !wr;
    wr_data_o <= data;
    byte_en_o <= lanes;
    // request held until taken
    do begin
      @(posedge clk_i);
      i++;
    end while (!ready_i && i < 400);
    if (!ready_i) stalls++;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~addr;
    wr_data_o <= ~data;
    if (!wr) begin
      do begin
        @(posedge clk_i);
        i++;
      end while (!rd_valid_i && i < 400);
      rdata = rd_data_i;
      if (!rd_valid_i) stalls++;
    end
  endtask
endmodule // host_cpu_model

/* File: verif/test_cipher_test_register_bridge.sv */
/*
  self-checking bench for the host bus bridge.
  assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ns
module test_cipher_test_register_bridge;
  logic core_clk_i, host_side_clk_i, nrst_i;
  logic [13:0] addr;
  logic wr, rd, ready, rd_valid;
  logic [31:0] wdata, rd_data;
  logic [3:0] be;
  logic [1:0] busy_v, done_v;
  cipher_bridge_pkg::core_status_t enc_st, dec_st;
  logic [127:0] enc_key, dec_key, plain_row, cipher_row;
  logic enc_kstb, dec_kstb, enc_start, dec_valid;
  int n_fail, comparisons;
  int pulses[4];
  // version words are arbitrary
  assign enc_st = {busy_v[0], done_v[0], 32'h1357_9BDF};
  assign dec_st = {busy_v[1], done_v[1], 32'h2468_ACE0};
  host_bus_bridge dut_u (.core_clk_i(core_clk_i), .host_side_clk_i(host_side_clk_i), .nrst_i(nrst_i),
    .host_word_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd), .host_wr_data_i(wdata), .host_byte_en_i(be),
    .host_ready_o(ready), .host_rd_valid_o(rd_valid), .host_rd_data_o(rd_data), .enc_status_i(enc_st),
    .enc_key_value_o(enc_key), .enc_key_load_strobe_o(enc_kstb), .enc_start_o(enc_start),
    .plain_row_o(plain_row), .dec_status_i(dec_st), .dec_key_value_o(dec_key),
    .dec_key_load_strobe_o(dec_kstb), .dec_input_valid_o(dec_valid), .cipher_row_o(cipher_row));
  host_cpu_model host_u (.clk_i(host_side_clk_i), .ready_i(ready), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wr_data_o(wdata), .byte_en_o(be));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    host_side_clk_i = 1'b0;
    forever #5 host_side_clk_i = ~host_side_clk_i;
  end
  always @(posedge core_clk_i) begin
    pulses[0] += int'(enc_start);
    pulses[1] += int'(dec_valid);
    pulses[2] += int'(enc_kstb);
    pulses[3] += int'(dec_kstb);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [15:0] off, input logic [31:0] d, input logic [3:0] lanes);
    logic [31:0] x;
    host_u.access(off[15:2], 1'b1, d, lanes, x);
    // the write still has to cross and fire its strobes on the core side
    repeat (6) @(posedge core_clk_i);
  endtask
  task automatic reg_rd(input logic [15:0] off, output logic [31:0] d);
    host_u.access(off[15:2], 1'b0, 32'h0, 4'hF, d);
  endtask
  task automatic t_mem;
    logic [31:0] d;
    host_u.access({5'h01, 9'h003}, 1'b1, 32'hA5A5_0003, 4'hF, d);
    host_u.access({5'h02, 9'h001}, 1'b1, 32'h5A5A_0001, 4'hF, d);
    host_u.access({5'h01, 9'h003}, 1'b0, 32'h0, 4'hF, d);
    chk(d, 32'hA5A5_0003);
    host_u.access({5'h02, 9'h001}, 1'b0, 32'h0, 4'hF, d);
    chk(d, 32'h5A5A_0001);
    repeat (4) @(posedge core_clk_i);
    chk(plain_row[127:96], 32'hA5A5_0003);
    chk(cipher_row[63:32], 32'h5A5A_0001);
    $display("done: sample memories");
  endtask
  task automatic t_ptr;
    logic [31:0] d;
    reg_wr(cipher_bridge_pkg::OFF_PLAIN_PTR, 32'hFFFF_FFFF, 4'hF);
    reg_rd(cipher_bridge_pkg::OFF_PLAIN_PTR, d);
    chk(d, 32'h0000_007F);
    reg_wr(cipher_bridge_pkg::OFF_CIPHER_PTR, 32'h0000_0001, 4'hE);
    reg_rd(cipher_bridge_pkg::OFF_CIPHER_PTR, d);
    chk(d, 32'h0000_0000);
    reg_wr(cipher_bridge_pkg::OFF_CIPHER_PTR, 32'h0000_0001, 4'h1);
    reg_rd(cipher_bridge_pkg::OFF_CIPHER_PTR, d);
    chk(d, 32'h0000_0001);
    $display("done: pointers");
  endtask
  // k selects the encryptor (0) or decryptor (1)
  task automatic t_count(input int k);
    logic [31:0] d;
    logic [15:0] off;
    int p;
    off = (k == 0) ? cipher_bridge_pkg::OFF_ENC_COUNT : cipher_bridge_pkg::OFF_DEC_COUNT;
    p = pulses[k];
    @(posedge core_clk_i);
    busy_v[k] <= 1'b1;
    reg_wr(off, 32'hFFFF_FF05, 4'h1);
    chk(32'(pulses[k] - p), 32'h1);
    reg_rd(off, d);
    chk(d, 32'h0000_0085);
    repeat (2) begin
      @(posedge core_clk_i);
      done_v[k] <= 1'b1;
      @(posedge core_clk_i);
      done_v[k] <= 1'b0;
    end
    @(posedge core_clk_i);
    busy_v[k] <= 1'b0;
    reg_rd(off, d);
    chk(d, 32'h0000_0003);
    $display("done: count %0d", k);
  endtask
  task automatic t_ver;
    logic [31:0] d;
    reg_wr(cipher_bridge_pkg::OFF_ENC_VERSION, 32'h0, 4'hF);
    reg_rd(cipher_bridge_pkg::OFF_ENC_VERSION, d);
    chk(d, 32'h1357_9BDF);
    reg_rd(cipher_bridge_pkg::OFF_DEC_VERSION, d);
    chk(d, 32'h2468_ACE0);
    reg_wr(16'h0010, 32'hFFFF_FFFF, 4'hF);
    reg_rd(16'h0010, d);
    chk(d, 32'h0);
    $display("done: versions");
  endtask
  task automatic t_key;
    logic [31:0] d;
    reg_wr(16'h0024, 32'h1111_2222, 4'hF);
    reg_wr(16'h002C, 32'h5555_6666, 4'hF);
    chk(32'(pulses[2]), 32'h0);
    chk(enc_key[127:96], 32'h5555_6666);
    reg_rd(16'h0024, d);
    chk(d, 32'h1111_2222);
    reg_wr(cipher_bridge_pkg::OFF_ENC_KEY0, 32'hAABB_CCDD, 4'hF);
    chk(32'(pulses[2]), 32'h1);
    chk(enc_key[31:0], 32'hAABB_CCDD);
    chk(enc_key[63:32], 32'h1111_2222);
    reg_rd(cipher_bridge_pkg::OFF_ENC_COUNT, d);
    chk({31'h0, d[8]}, 32'h1);
    repeat (30) @(posedge core_clk_i);
    reg_rd(cipher_bridge_pkg::OFF_ENC_COUNT, d);
    chk({31'h0, d[8]}, 32'h0);
    reg_wr(16'h0044, 32'h7777_8888, 4'hF);
    reg_wr(cipher_bridge_pkg::OFF_DEC_KEY0, 32'h0102_0304, 4'hF);
    chk(32'(pulses[3]), 32'h1);
    chk(dec_key[63:32], 32'h7777_8888);
    $display("done: keys");
  endtask
  task automatic summarize;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    summarize();
  end
  initial begin
    nrst_i = 1'b0;
    busy_v = 2'b00;
    done_v = 2'b00;
    repeat (10) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_mem();
    t_ptr();
    t_count(0);
    t_count(1);
    t_ver();
    t_key();
    chk(32'(host_u.stalls), 32'h0);
    summarize();
  end
endmodule // test_cipher_test_register_bridge
